//--- cfgl_flash_model.sv
`default_nettype none
// ==========
// serial flash: wake, fast read, byte k holds k*29+53
module cfgl_flash_model
(
   input  wire logic        i_sclk,
   input  wire logic        i_cs_n,
   input  wire logic        i_mosi,
   output var  logic        o_miso,
   output var  logic [7:0]  o_wake,
   output var  logic [39:0] o_cmd
);
   timeunit 1ns;
   timeprecision 1ps;
   int          cnt = 0;  // rises seen in this select
   logic [39:0] sh;       // command shifter
   // one data bit, msb first
   function automatic logic dbit(int b);
      logic [7:0] v;
      v = 8'(b / 8 * 29 + 53);
      return v[7 - b % 8];
   endfunction
   initial
   begin
      o_miso = 1'b0;
   end
   always @(negedge i_cs_n)
      cnt = 0;
   // command in on rise; data out on rise so the loader takes it on fall
   always @(posedge i_sclk)
   begin
      if (!i_cs_n)
      begin
         sh = {sh[38:0], i_mosi};
         if (cnt == 39)
            o_cmd <= sh;
         // after 40 command bits stream from address zero
         if (cnt >= 40)
            o_miso <= dbit(cnt - 40);
         else
            o_miso <= ~o_miso;  // undriven: never a stale level
         cnt++;
      end
   end
   // a select of exactly 8 bits is the wake instruction
   always @(posedge i_cs_n)
   begin
      if (cnt == 8)
         o_wake <= sh[7:0];
      o_miso <= ~o_miso;  // released line
   end
endmodule
`default_nettype wire

//--- cfgl_loader.sv
// Contract
// RULE1: full load before user mode, every power-up
// RULE2: active load timed by oscillator or external clock
// RULE3: active load starts with flash wake instruction
// RULE4: wait 30 us, then fast read from zero
// RULE5: passive mode only follows the external master
// RULE6: master waits 32 us before sending data
// RULE7: master holds reset low minimum time first
// RULE8: jtag port is a third load path
// RULE9: x16 and x32 refused when security enabled
// RULE10: failed signature check halts, no user mode
// RULE11: reset rising edge restarts load, discards data
`include "cfgl_params.svh"
`default_nettype none
module cfgl_loader
   import cfgl_pkg::*;
#(
   parameter int CFG_BYTES = `CFGL_CFG_BYTES,
   parameter int SPI_DIV   = `CFGL_SPI_DIV
)
(
   input  wire logic        i_clk,
   input  wire logic        i_rst,
   input  wire logic        i_config_reset_n,
   input  wire logic [1:0]  i_mode,
   input  wire logic        i_ext_clk_sel,
   input  wire logic        i_external_config_clock,
   input  wire logic        i_encrypt_en,
   input  wire logic        i_auth_en,
   input  wire logic        i_sig_done,
   input  wire logic        i_sig_ok,
   input  wire logic        i_spi_miso,
   output var  logic        o_spi_sclk,
   output var  logic        o_spi_cs_n,
   output var  logic        o_spi_mosi,
   output var  logic        o_spi_oe,
   input  wire logic        i_pas_clk,
   input  wire logic        i_pas_cs_n,
   input  wire logic [2:0]  i_pas_width,
   input  wire logic [31:0] i_pas_data,
   input  wire logic        i_jtag_tck,
   input  wire logic        i_jtag_tdi,
   output var  logic        o_config_ram_cells_valid,
   output var  logic [7:0]  o_config_ram_cells_data,
   input  wire logic        i_config_ram_cells_ready,
   output var  logic        o_config_ram_cells_restart,
   output var  logic        o_user_mode,
   output var  logic        o_cfg_error
);
   // ==========================================================
   // constants
   localparam int          WAKE_CYC   = `CFGL_WAKE_CYC;
   localparam logic [15:0] WAKE_LAST  = 16'(WAKE_CYC - 1);
   localparam logic [7:0]  DIV_LAST   = 8'(SPI_DIV - 1);
   localparam logic [23:0] LAST_BYTE  = 24'(CFG_BYTES - 1);
   localparam logic [23:0] FULL_BYTES = 24'(CFG_BYTES);
   localparam logic [39:0] READ_WORD  = {`CFGL_FREAD_CMD, `CFGL_FLASH_ADDR, `CFGL_DUMMY};
   localparam logic [7:0]  WAKE_BYTE  = `CFGL_WAKE_CMD;

   // ==========================================================
   // main domain state
   typedef struct packed {
      cfgl_state_t state;      // sequencer
      logic        crn1;       // config reset synchroniser
      logic        crn2;
      logic        crn3;       // edge history
      logic [1:0]  mode1;      // mode strap synchroniser
      logic [1:0]  mode2;
      logic [2:0]  wid1;       // width strap synchroniser
      logic [2:0]  wid2;
      logic        sel1;       // clock select synchroniser
      logic        sel2;
      logic        miso1;      // flash data synchroniser
      logic        miso2;
      logic        ext1;       // external config clock sampler
      logic        ext2;
      logic        ext3;
      logic        tck1;       // jtag clock sampler
      logic        tck2;
      logic        tck3;
      logic        tdi1;
      logic        tdi2;
      logic        tog1;       // word toggle from link domain
      logic        tog2;
      logic        tog3;
      logic [7:0]  div;        // oscillator divider
      logic [15:0] gap;        // wake gap counter
      logic [39:0] sh;         // instruction shifter
      logic [5:0]  nbits;      // bits moved
      logic [7:0]  rx;         // byte assembly
      logic [23:0] nbytes;     // bytes delivered
      logic [31:0] word;       // passive word being unpacked
      logic        wpend;
      logic [1:0]  widx;
      logic        sclk;
      logic        cs_n;
      logic        mosi;
      logic        spi_oe;
      logic [7:0]  e0;         // buffer head
      logic [7:0]  e1;         // buffer second entry
      logic        v0;
      logic        v1;
      logic        user;
      logic        err;
      logic        restart;
   } cfgl_main_t;

   // link domain state
   typedef struct packed {
      logic        rst1;       // reset synchroniser
      logic        rst2;
      logic [2:0]  wid1;       // width strap synchroniser
      logic [2:0]  wid2;
      logic [31:0] acc;        // bit accumulator
      logic [5:0]  cnt;        // bits held
      logic [31:0] word;       // stable word for the main side
      logic        tog;        // flips once per finished word
   } cfgl_link_t;

   cfgl_main_t st_reg;
   cfgl_main_t st_next;
   cfgl_link_t lk_reg;
   cfgl_link_t lk_next;

   logic        cfg_rise;      // released reset seen
   logic        tick_w;        // flash clock half-period step
   logic        sec_wide;      // wide bus with security on
   logic        spi_run;       // sequencer drives the flash
   logic        push;
   logic [7:0]  pdat;
   logic [31:0] lacc;
   logic [5:0]  lstep;

   assign cfg_rise = st_reg.crn2 && !st_reg.crn3;
   assign tick_w   = st_reg.sel2 ? (st_reg.ext2 && !st_reg.ext3) : (st_reg.div == 8'h00);
   assign sec_wide = (i_encrypt_en || i_auth_en) &&
                     (st_reg.wid2 == CFGL_X16 || st_reg.wid2 == CFGL_X32);
   assign spi_run  = st_reg.state inside {ST_WAKE, ST_READ_CMD, ST_STREAM};

   // ==========================================================
   // main next-state logic
   always_comb
   begin
      st_next = st_reg;
      push = 1'b0;
      pdat = 8'h00;
      // pin synchronisers, first stage feeds only the second
      st_next.crn1  = i_config_reset_n;
      st_next.crn2  = st_reg.crn1;
      st_next.crn3  = st_reg.crn2;
      st_next.mode1 = i_mode;
      st_next.mode2 = st_reg.mode1;
      st_next.wid1  = i_pas_width;
      st_next.wid2  = st_reg.wid1;
      st_next.sel1  = i_ext_clk_sel;
      st_next.sel2  = st_reg.sel1;
      st_next.miso1 = i_spi_miso;
      st_next.miso2 = st_reg.miso1;
      st_next.ext1  = i_external_config_clock;
      st_next.ext2  = st_reg.ext1;
      st_next.ext3  = st_reg.ext2;
      st_next.tck1  = i_jtag_tck;
      st_next.tck2  = st_reg.tck1;
      st_next.tck3  = st_reg.tck2;
      st_next.tdi1  = i_jtag_tdi;
      st_next.tdi2  = st_reg.tdi1;
      st_next.tog1  = lk_reg.tog;
      st_next.tog2  = st_reg.tog1;
      st_next.tog3  = st_reg.tog2;
      st_next.restart = 1'b0;
      // free-running oscillator divider
      st_next.div = (st_reg.div == 8'h00) ? DIV_LAST : st_reg.div - 8'h01;
      // buffer drain toward the config ram cells
      if (st_reg.v0 && i_config_ram_cells_ready)
      begin
         st_next.e0 = st_reg.e1;
         st_next.v0 = st_reg.v1;
         st_next.v1 = 1'b0;
      end
      unique case (st_reg.state)
         ST_WAKE, ST_READ_CMD:
         begin
            // instruction out, msb first, flash samples on rising sclk
            if (tick_w)                                              // RULE2
            begin
               if (!st_reg.sclk)
                  st_next.sclk = 1'b1;
               else
               begin
                  st_next.sclk  = 1'b0;
                  st_next.sh    = {st_reg.sh[38:0], 1'b0};
                  st_next.mosi  = st_reg.sh[38];
                  st_next.nbits = st_reg.nbits + 6'h01;
                  if (st_reg.state == ST_WAKE && st_reg.nbits == `CFGL_WAKE_BITS - 6'h01)
                  begin
                     // wake sent: release the flash and wait
                     st_next.cs_n  = 1'b1;                           // RULE3
                     st_next.gap   = 16'h0000;
                     st_next.state = ST_GAP;
                  end
                  else if (st_reg.state == ST_READ_CMD && st_reg.nbits == `CFGL_READ_BITS - 6'h01)
                  begin
                     st_next.nbits = 6'h00;
                     st_next.mosi  = 1'b0;
                     st_next.state = ST_STREAM;
                  end
               end
            end
         end
         ST_GAP:
         begin
            // least wake time before the fast read
            st_next.gap = st_reg.gap + 16'h0001;
            if (st_reg.gap == WAKE_LAST)                             // RULE4
            begin
               st_next.cs_n  = 1'b0;
               st_next.sh    = READ_WORD;
               st_next.mosi  = READ_WORD[39];
               st_next.nbits = 6'h00;
               st_next.state = ST_READ_CMD;
            end
         end
         ST_STREAM:
         begin
            // flash clock stalls while the buffer is full, no byte is lost
            if (tick_w && !st_reg.v1)                                // RULE2
            begin
               if (!st_reg.sclk)
                  st_next.sclk = 1'b1;
               else
               begin
                  st_next.sclk  = 1'b0;
                  st_next.rx    = {st_reg.rx[6:0], st_reg.miso2};
                  st_next.nbits = st_reg.nbits + 6'h01;
                  if (st_reg.nbits[2:0] == 3'h7)
                  begin
                     push = 1'b1;
                     pdat = {st_reg.rx[6:0], st_reg.miso2};
                  end
               end
            end
         end
         ST_PASSIVE:
         begin
            // words arrive from the master's clock domain
            if (st_reg.tog2 != st_reg.tog3)                          // RULE5
            begin
               if (st_reg.wpend)
               begin
                  st_next.err   = 1'b1;
                  st_next.state = ST_HALT;
               end
               else
               begin
                  st_next.word  = lk_reg.word;
                  st_next.wpend = 1'b1;
                  st_next.widx  = 2'h0;
               end
            end
            else if (st_reg.wpend && !st_reg.v1)
            begin
               push = 1'b1;
               pdat = st_reg.word[{~st_reg.widx, 3'h7} -: 8];
               st_next.widx = st_reg.widx + 2'h1;
               if (st_reg.widx == 2'h3)
                  st_next.wpend = 1'b0;
            end
         end
         ST_JTAG:
         begin
            // one bit per sampled tck rise; a rise with no room is fatal
            if (st_reg.tck2 && !st_reg.tck3)                         // RULE8
            begin
               if (st_reg.v1)
               begin
                  st_next.err   = 1'b1;
                  st_next.state = ST_HALT;
               end
               else
               begin
                  st_next.rx    = {st_reg.rx[6:0], st_reg.tdi2};
                  st_next.nbits = st_reg.nbits + 6'h01;
                  if (st_reg.nbits[2:0] == 3'h7)
                  begin
                     push = 1'b1;
                     pdat = {st_reg.rx[6:0], st_reg.tdi2};
                  end
               end
            end
         end
         ST_VERIFY:
         begin
            if (i_sig_done)
            begin
               st_next.err   = !i_sig_ok;                            // RULE10
               st_next.state = i_sig_ok ? ST_USER : ST_HALT;
            end
         end
         ST_USER:
         begin
            // user mode only once the last byte has left the buffer,
            // otherwise a stalled receiver would still miss config bytes
            if (!st_reg.v0)
               st_next.user = 1'b1;                                  // RULE1
         end
         default:
         begin
            // idle and halt wait for the next reset release
         end
      endcase
      // buffer fill and end of load
      if (push)
      begin
         if (!st_next.v0)
         begin
            st_next.e0 = pdat;
            st_next.v0 = 1'b1;
         end
         else
         begin
            st_next.e1 = pdat;
            st_next.v1 = 1'b1;
         end
         st_next.nbytes = st_reg.nbytes + 24'h000001;
         if (st_reg.nbytes == LAST_BYTE)                             // RULE1
         begin
            st_next.cs_n   = 1'b1;
            st_next.sclk   = 1'b0;
            st_next.spi_oe = 1'b0;
            st_next.state  = i_auth_en ? ST_VERIFY : ST_USER;
         end
      end
      // reset pin low: drop everything; rising edge: start again
      if (!st_reg.crn2 || cfg_rise)                                  // RULE11
      begin
         st_next.state   = ST_IDLE;
         st_next.user    = 1'b0;
         st_next.err     = 1'b0;
         st_next.v0      = 1'b0;
         st_next.v1      = 1'b0;
         st_next.wpend   = 1'b0;
         st_next.nbytes  = 24'h000000;
         st_next.nbits   = 6'h00;
         st_next.sclk    = 1'b0;
         st_next.mosi    = 1'b0;
         st_next.cs_n    = 1'b1;
         st_next.spi_oe  = 1'b0;
         st_next.restart = cfg_rise;
      end
      if (cfg_rise)
      begin
         if (st_reg.mode2 == CFGL_ACTIVE)
         begin
            st_next.state  = ST_WAKE;                                // RULE3
            st_next.spi_oe = 1'b1;
            st_next.cs_n   = 1'b0;
            st_next.sh     = {`CFGL_WAKE_CMD, 32'h00000000};
            st_next.mosi   = WAKE_BYTE[7];
         end
         else if (st_reg.mode2 == CFGL_PASSIVE)
         begin
            // wide passive buses are refused under encryption or signing
            st_next.state = sec_wide ? ST_HALT : ST_PASSIVE;         // RULE9
            st_next.err   = sec_wide;
         end
         else if (st_reg.mode2 == CFGL_JTAG)
            st_next.state = ST_JTAG;                                 // RULE8
         else
         begin
            st_next.state = ST_HALT;
            st_next.err   = 1'b1;
         end
      end
   end

   // main state register
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         st_reg      <= '0;
         st_reg.cs_n <= 1'b1;
      end
      else
         st_reg <= st_next;
   end

   // ==========================================================
   // link domain: gather master bits into 32-bit words
   always_comb
   begin
      lk_next = lk_reg;
      lk_next.rst1 = i_rst;
      lk_next.rst2 = lk_reg.rst1;
      lk_next.wid1 = i_pas_width;
      lk_next.wid2 = lk_reg.wid1;
      unique case (lk_reg.wid2)
         CFGL_X2:
         begin
            lacc  = {lk_reg.acc[29:0], i_pas_data[1:0]};
            lstep = 6'h02;
         end
         CFGL_X4:
         begin
            lacc  = {lk_reg.acc[27:0], i_pas_data[3:0]};
            lstep = 6'h04;
         end
         CFGL_X8:
         begin
            lacc  = {lk_reg.acc[23:0], i_pas_data[7:0]};
            lstep = 6'h08;
         end
         CFGL_X16:
         begin
            lacc  = {lk_reg.acc[15:0], i_pas_data[15:0]};
            lstep = 6'h10;
         end
         CFGL_X32:
         begin
            lacc  = i_pas_data;
            lstep = 6'h20;
         end
         default:
         begin
            // x1 and unused codes take one bit
            lacc  = {lk_reg.acc[30:0], i_pas_data[0]};
            lstep = 6'h01;
         end
      endcase
      // the frame's own select ends a partial word
      if (i_pas_cs_n)
         lk_next.cnt = 6'h00;
      else
      begin
         lk_next.acc = lacc;
         lk_next.cnt = lk_reg.cnt + lstep;
         if (lk_reg.cnt + lstep == 6'h20)
         begin
            lk_next.cnt  = 6'h00;
            lk_next.word = lacc;
            lk_next.tog  = ~lk_reg.tog;
         end
      end
      if (lk_reg.rst2)
      begin
         lk_next.acc  = 32'h00000000;
         lk_next.cnt  = 6'h00;
         lk_next.word = 32'h00000000;
         lk_next.tog  = 1'b0;
      end
   end

   // link state register
   always_ff @(posedge i_pas_clk)
   begin
      lk_reg <= lk_next;
   end

   // ==========================================================
   // outputs straight from flops
   assign o_spi_sclk     = st_reg.sclk;
   assign o_spi_cs_n     = st_reg.cs_n;
   assign o_spi_mosi     = st_reg.mosi;
   assign o_spi_oe       = st_reg.spi_oe;
   assign o_config_ram_cells_valid   = st_reg.v0;
   assign o_config_ram_cells_data    = st_reg.e0;
   assign o_config_ram_cells_restart = st_reg.restart;
   assign o_user_mode    = st_reg.user;
   assign o_cfg_error    = st_reg.err;

   // ==========================================================
   // checks
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_rst);

   sequence act_start_s;
      cfg_rise && st_reg.mode2 == CFGL_ACTIVE;
   endsequence
   sequence read_entry_s;
      st_reg.state == ST_READ_CMD && $past(st_reg.state) == ST_GAP;
   endsequence
   sequence jtag_edge_s;
      st_reg.state == ST_JTAG && st_reg.tck2 && !st_reg.tck3 && !st_reg.v1 && st_reg.crn2 && !cfg_rise;
   endsequence

   user_after_load_a: assert property (o_user_mode |-> st_reg.nbytes == FULL_BYTES) // RULE1
      else $error("user mode without a full load");
   spi_tick_a: assert property (spi_run && $past(spi_run) && $changed(o_spi_sclk) |-> $past(tick_w)) // RULE2
      else $error("flash clock moved without a tick");
   wake_first_a: assert property (act_start_s |=> st_reg.state == ST_WAKE && !o_spi_cs_n && o_spi_mosi) // RULE3
      else $error("active load did not start with wake");
   wake_gap_a: assert property (read_entry_s |-> $past(st_reg.gap) == WAKE_LAST && $past(o_spi_cs_n)) // RULE4
      else $error("fast read before the wake gap");
   read_cmd_a: assert property (read_entry_s |-> st_reg.sh == READ_WORD && !o_spi_cs_n) // RULE4
      else $error("fast read command or address wrong");
   passive_target_a: assert property (st_reg.state == ST_PASSIVE |-> !o_spi_oe && o_spi_cs_n) // RULE5
      else $error("flash pins driven in passive mode");
   jtag_shift_a: assert property (jtag_edge_s |=> st_reg.nbits == 6'($past(st_reg.nbits) + 1)) // RULE8
      else $error("jtag bit not taken");
   secure_width_a: assert property (cfg_rise && st_reg.mode2 == CFGL_PASSIVE && sec_wide
                                    |=> st_reg.state == ST_HALT && o_cfg_error) // RULE9
      else $error("wide passive bus accepted with security");
   auth_halt_a: assert property (st_reg.state == ST_VERIFY && i_sig_done && !i_sig_ok && st_reg.crn2 && !cfg_rise
                                 |=> st_reg.state == ST_HALT && !o_user_mode ##1 !o_user_mode) // RULE10
      else $error("bad signature did not halt");
   restart_clean_a: assert property (cfg_rise |=> st_reg.nbytes == 24'h000000 && !o_user_mode && o_config_ram_cells_restart) // RULE11
      else $error("restart kept old load");
endmodule
`default_nettype wire

//--- cfgl_loader_tb_top.sv
`include "cfgl_params.svh"
`default_nettype none
// ==========
// loader bench: active, passive and jtag loads
module cfgl_loader_tb_top;
   import cfgl_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int NB = 8;  // bytes per load, short for sim
   logic        clk, rst, cfg_rst_n, ecs, ecc, enc, auth, sd, sok, miso, sclk, cs_n, mosi, oe;
   logic        pclk, pcs_n, tck, tdi, cv, crdy, crs, um, err;
   logic [1:0]  mode;
   logic [2:0]  pw;
   logic [31:0] pd;
   logic [7:0]  cd, wake;
   logic [39:0] cmd;
   logic [7:0]  got[$], exq[$];  // received and expected bytes
   int          err_total = 0, n_compared = 0, gap = 0, gap_seen = 0, rs_cnt = 0;
   int          seed = 32'hd25fb35f;
   cfgl_loader #(.CFG_BYTES(NB), .SPI_DIV(4)) dut (.i_clk(clk), .i_rst(rst), .i_config_reset_n(cfg_rst_n),
      .i_mode(mode), .i_ext_clk_sel(ecs), .i_external_config_clock(ecc), .i_encrypt_en(enc), .i_auth_en(auth),
      .i_sig_done(sd), .i_sig_ok(sok), .i_spi_miso(miso), .o_spi_sclk(sclk), .o_spi_cs_n(cs_n),
      .o_spi_mosi(mosi), .o_spi_oe(oe), .i_pas_clk(pclk), .i_pas_cs_n(pcs_n), .i_pas_width(pw),
      .i_pas_data(pd), .i_jtag_tck(tck), .i_jtag_tdi(tdi), .o_config_ram_cells_valid(cv), .o_config_ram_cells_data(cd),
      .i_config_ram_cells_ready(crdy), .o_config_ram_cells_restart(crs), .o_user_mode(um), .o_cfg_error(err));
   cfgl_flash_model flash (.i_sclk(sclk), .i_cs_n(cs_n), .i_mosi(mosi), .o_miso(miso), .o_wake(wake), .o_cmd(cmd));
   always #12.5 clk = ~clk;
   always #53 ecc = ~ecc;  // external configuration clock, free running, slow enough for the miso sync
   // random stalls of the receiver
   always @(negedge clk)
      crdy <= 1'($random(seed));
   // collect bytes; measure the select gap between wake and read
   always @(posedge clk)
   begin
      if (crs === 1'b1)
      begin
         got.delete();
         gap = 0;
         rs_cnt++;
      end
      else if (cv === 1'b1 && crdy === 1'b1)
         got.push_back(cd);
      if (oe === 1'b1 && cs_n === 1'b1)
         gap++;
      else if (cs_n === 1'b0 && gap != 0)
      begin
         gap_seen = gap;
         gap = 0;
      end
   end
   task automatic chk(string nm, logic [63:0] exp, logic [63:0] seen);
      n_compared++;
      if (seen !== exp)
      begin
         err_total++;
         $display("FAIL %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic end_sim();
      if (err_total == 0 && n_compared > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // hold the reset pin low, then let it rise to start a load
   task automatic start(logic [1:0] m);
      @(negedge clk);
      cfg_rst_n = 1'b0;
      mode = m;
      repeat (10) @(negedge clk);
      cfg_rst_n = 1'b1;
   endtask
   task automatic wait_end();
      for (int i = 0; i < 20000 && um !== 1'b1 && err !== 1'b1; i++)
         @(negedge clk);
   endtask
   task automatic act_exp();
      for (int k = 0; k < NB; k++)
         exq.push_back(8'(k * 29 + 53));
   endtask
   task automatic chk_bytes();
      chk("byte count", NB, got.size());
      foreach (exq[k])
         chk("config_ram_cells byte", exq[k], got[k]);
      exq.delete();
      got.delete();
   endtask
   // link frame: words msb first, w bits per link clock, clock still outside
   task automatic pas_load(logic [2:0] code);
      int          w;
      logic [31:0] wd;
      w = 1 << code;
      pw = code;
      repeat (4) #80 pclk = ~pclk;  // two link edges carry the width into the link domain
      start(2'h1);
      repeat (1290) @(negedge clk);
      pcs_n = 1'b0;
      for (int n = 0; n < NB / 4; n++)
      begin
         wd = $random(seed);
         for (int b = 0; b < 4; b++)
            exq.push_back(wd[31 - 8 * b -: 8]);
         for (int e = 0; e < 32 / w; e++)
         begin
            pd = wd >> (32 - w * (e + 1));
            #80 pclk = 1'b1;
            #80 pclk = 1'b0;
         end
      end
      pcs_n = 1'b1;
      pd = ~pd;
   endtask
   // jtag bits msb first, slow test clock
   task automatic jtag_load();
      logic [7:0] b;
      start(2'h2);
      for (int k = 0; k < NB; k++)
      begin
         b = 8'($random(seed));
         exq.push_back(b);
         for (int i = 7; i >= 0; i--)
         begin
            tdi = b[i];
            repeat (4) @(negedge clk);
            tck = 1'b1;
            repeat (4) @(negedge clk);
            tck = 1'b0;
         end
      end
   endtask
   initial
   begin
      {clk, cfg_rst_n, ecs, ecc, enc, auth, sd, sok, pclk, tck, tdi, crdy, mode, pw, pd} = '0;
      {rst, pcs_n} = 2'h3;
      repeat (6) #80 pclk = ~pclk;  // link reset needs its clock
      repeat (20) @(negedge clk);
      rst = 1'b0;
      // active load aborted mid-gap, then run whole
      act_exp();
      start(2'h0);
      repeat (600) @(negedge clk);
      start(2'h0);
      repeat (700) @(negedge clk);
      chk("early user", 0, um);
      wait_end();
      chk_bytes();
      chk("wake", `CFGL_WAKE_CMD, wake);
      chk("read cmd", {`CFGL_FREAD_CMD, `CFGL_FLASH_ADDR, `CFGL_DUMMY}, cmd);
      chk("gap", `CFGL_WAKE_CYC, gap_seen);
      chk("restarts", 2, rs_cnt);
      chk("user", 1, um);
      // flash clock from the external pin
      ecs = 1'b1;
      act_exp();
      start(2'h0);
      wait_end();
      chk_bytes();
      ecs = 1'b0;
      // signature fails, then passes, after the last byte
      auth = 1'b1;
      for (int ok = 0; ok < 2; ok++)
      begin
         act_exp();
         start(2'h0);
         for (int i = 0; i < 20000 && got.size() < NB; i++)
            @(negedge clk);
         repeat (3) @(negedge clk);
         chk("auth wait", 0, um);
         {sd, sok} = {1'b1, 1'(ok)};
         @(negedge clk);
         sd = 1'b0;
         repeat (50) @(negedge clk);
         chk("auth err", 1 - ok, err);
         chk("auth user", ok, um);
         chk_bytes();
      end
      auth = 1'b0;
      // passive x8 with security on stays usable
      enc = 1'b1;
      pas_load(3'h3);
      wait_end();
      chk_bytes();
      chk("x8 user", 1, um);
      pw = 3'h4;
      start(2'h1);
      repeat (30) @(negedge clk);
      chk("x16 err", 1, err);
      // unused mode code halts with an error
      start(2'h3);
      repeat (30) @(negedge clk);
      chk("bad mode", 1, err);
      enc = 1'b0;
      jtag_load();
      wait_end();
      chk_bytes();
      chk("jtag user", 1, um);
      end_sim();
   end
   initial
   begin
      #2ms;
      err_total++;
      end_sim();
   end
endmodule
`default_nettype wire

//--- cfgl_params.svh
`ifndef CFGL_PARAMS_SVH
`define CFGL_PARAMS_SVH
// ==========================================================
// flash command bytes and read address
`define CFGL_WAKE_CMD   8'hab
`define CFGL_FREAD_CMD  8'h0b
`define CFGL_FLASH_ADDR 24'h000000
`define CFGL_DUMMY      8'h00
// bit counts of the two flash instructions
`define CFGL_WAKE_BITS  6'h08
`define CFGL_READ_BITS  6'h28
// ==========================================================
// timing: system clock rate and flash wake gap
`define CFGL_CLK_KHZ    40000
`define CFGL_WAKE_US    30
// least time, so the cycle count rounds up
`define CFGL_WAKE_CYC   ((`CFGL_WAKE_US * `CFGL_CLK_KHZ + 999) / 1000)
// ==========================================================
// defaults for module parameters
`define CFGL_SPI_DIV    4
`define CFGL_CFG_BYTES  1024
`endif

//--- cfgl_pkg.sv
`default_nettype none
// ==========================================================
// types shared by the configuration loader
package cfgl_pkg;
   // load method, as strapped on the mode pins
   typedef enum logic [1:0] {CFGL_ACTIVE, CFGL_PASSIVE, CFGL_JTAG} cfgl_mode_t;
   // passive bus width code
   typedef enum logic [2:0] {CFGL_X1, CFGL_X2, CFGL_X4, CFGL_X8, CFGL_X16, CFGL_X32} cfgl_width_t;
   // sequencer states
   typedef enum logic [3:0] {
      ST_IDLE, ST_WAKE, ST_GAP, ST_READ_CMD, ST_STREAM,
      ST_PASSIVE, ST_JTAG, ST_VERIFY, ST_USER, ST_HALT
   } cfgl_state_t;
endpackage
`default_nettype wire
